/* File: bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    // ------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------
    logic                 core_clk;
    logic                 rst_b;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [7:0]           paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 irq;
    logic                 opStart;
    flc_pkg::flc_op_t     opCmd;
    flc_pkg::flc_op_end_t opEnd;
    logic                 resValid;
    logic [31:0]          resData;
    logic [31:0]          rdData;
    logic                 rdErr;
    logic [23:0]          lastCmd;
    logic [31:0]          words [3];
    int                   nStart = 0;
    int                   n_errors;
    int                   compares;

    flc_cmd_status flc_cmd_status_i (
        .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .opStart(opStart),
        .opCmd(opCmd), .opEnd(opEnd), .resValid(resValid), .resData(resData)
    );

    // free running 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // launches counted mid-cycle, away from the edge race
    always @(negedge core_clk) begin
        if (opStart === 1'b1) begin
            nStart++;
            lastCmd = opCmd;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t ns %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one apb transfer; request held until the edge that sees pready high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 16) begin
                n_errors++;
                $display("ERROR %0t ns no pready", $time);
                close_out();
            end
            @(posedge core_clk);
        end
        // answer taken at the completing edge, then released
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rchk(input logic [7:0] addr, input logic [31:0] exp, input string what);
        apb(1'b0, addr, 32'h0000_0000);
        chk(rdData, exp, what);
    endtask

    // irq is registered, so give it two edges to settle
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0000_0000, irq}, {31'h0000_0000, exp}, "irq");
    endtask

    // back end pulse: {done, lockHit, verifyFail}
    task automatic pulse(input logic [2:0] e);
        opEnd <= e;
        @(posedge core_clk);
        opEnd <= 3'h0;
        @(posedge core_clk);
    endtask

    task automatic push(input logic [31:0] d);
        resValid <= 1'b1;
        resData  <= d;
        @(posedge core_clk);
        resValid <= 1'b0;
        @(posedge core_clk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; opEnd = 3'h0;
        resValid = 1'b0; resData = 32'h0000_0000;
        n_errors = 0; compares = 0;
        words = '{32'h1111_0001, 32'h2222_0002, 32'h3333_0003};
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rchk(flc_pkg::ADDR_MODE, flc_pkg::MODE_RESET, "mode reset");
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0001, "status reset");
        // wrong key: dropped, flagged, then cleared by the read
        apb(1'b1, flc_pkg::ADDR_CMD, 32'hA501_0001);
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0003, "bad key");
        chk(32'(nStart), 32'h0000_0000, "bad key start");
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0001, "read clear");
        // unassigned codes with the right key
        apb(1'b1, flc_pkg::ADDR_CMD, 32'h5A00_0006);
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0003, "hole code");
        apb(1'b1, flc_pkg::ADDR_CMD, 32'h5A00_0016);
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0003, "high code");
        apb(1'b1, flc_pkg::ADDR_CMD, 32'h5A00_00FF);
        // ready interrupt enable, other MODE_WMASK bits plain storage, the rest read zero
        apb(1'b1, flc_pkg::ADDR_MODE, 32'hFFFF_FFFF);
        rchk(flc_pkg::ADDR_MODE, flc_pkg::MODE_WMASK, "mode mask");
        irq_chk(1'b1);
        // good command also wipes the stale command error
        apb(1'b1, flc_pkg::ADDR_CMD, 32'h5A12_3401);
        chk(32'(nStart), 32'h0000_0001, "launch");
        chk({8'h00, lastCmd}, 32'h0012_3401, "op cmd");
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0000, "busy");
        irq_chk(1'b0);
        // write while busy is refused
        apb(1'b1, flc_pkg::ADDR_CMD, 32'h5A00_0001);
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0002, "busy write");
        chk(32'(nStart), 32'h0000_0001, "busy start");
        pulse(3'h2);
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0004, "lock err");
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0000, "lock clear");
        for (int i = 0; i < 3; i++) begin
            push(words[i]);
        end
        pulse(3'h5);
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0009, "verify fail");
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0009, "verify hold");
        irq_chk(1'b1);
        for (int i = 0; i < 3; i++) begin
            rchk(flc_pkg::ADDR_RESULT, words[i], "result");
        end
        rchk(flc_pkg::ADDR_RESULT, 32'h0000_0000, "result end");
        // event status, mask and write-one-to-clear
        rchk(flc_pkg::ADDR_EVT_STAT, 32'h0000_000F, "events");
        apb(1'b1, flc_pkg::ADDR_MODE, 32'h0000_0000);
        irq_chk(1'b0);
        apb(1'b1, flc_pkg::ADDR_EVT_MASK, 32'h0000_0004);
        irq_chk(1'b1);
        apb(1'b1, flc_pkg::ADDR_EVT_STAT, 32'h0000_0004);
        irq_chk(1'b0);
        rchk(flc_pkg::ADDR_EVT_STAT, 32'h0000_000B, "evt clear");
        // next command: verify error cleared, result pointer restarts
        apb(1'b1, flc_pkg::ADDR_CMD, 32'h5A00_0000);
        chk(32'(nStart), 32'h0000_0002, "relaunch");
        push(32'hABCD_0123);
        pulse(3'h4);
        rchk(flc_pkg::ADDR_STATUS, 32'h0000_0001, "verify pass");
        rchk(flc_pkg::ADDR_RESULT, 32'hABCD_0123, "ptr restart");
        // unmapped address
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk({31'h0000_0000, rdErr}, 32'h0000_0001, "slverr");
        chk(rdData, 32'h0000_0000, "unmapped data");
        close_out();
    end
endmodule

/* File: design/flc_cmd_check.sv */
`timescale 1ns/1ns
// command word screening: key and code legality
module flc_cmd_check (
    input  wire flc_pkg::flc_cmd_word_t cmdWord,
    output logic                         keyOk,
    output logic                         codeOk
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // key must match
    assign keyOk  = (cmdWord.protectKeyField == flc_pkg::KEY_PASS_VALUE);
    // table has one hole below the last code
    assign codeOk = (cmdWord.code <= flc_pkg::CMD_LAST) && (cmdWord.code != flc_pkg::CMD_HOLE);
endmodule

/* File: design/flc_cmd_status.sv */
// Local design decision: register access over APB.
`timescale 1ns/1ns
// Notes on behaviour
// - a command starts only when its key field holds the pass value
// - a command write with a wrong key is dropped and starts nothing
// - status bit 0 reads 0 while busy and 1 when a command can be taken
// - ready with its enable set raises the interrupt
// - ready drops by itself when a command starts executing
// - status bit 1 sets on an unknown code or a wrong key
// - command and lock error clear on status read or command write
// - status bit 2 sets when program or erase touched a locked region
// - status bit 3 shows verify failure at operation end, 0 on pass
// - command output values land in the read-only result register
// - each result read returns the next 32-bit word
// - mode bit 0 enables the ready level interrupt; with 0 the ready event can still raise it through mask bit 0
// - a bad key is reported as command error after the sequence
module flc_cmd_status #(
    parameter int RES_DEPTH = flc_pkg::RES_DEPTH
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq,
    output logic                       opStart,
    output flc_pkg::flc_op_t           opCmd,
    input  wire flc_pkg::flc_op_end_t  opEnd,
    input  wire logic                  resValid,
    input  wire logic [31:0]           resData
);
    localparam int PW = (RES_DEPTH > 1) ? $clog2(RES_DEPTH) : 1;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                  preadyReg;
    logic [31:0]           prdataReg;
    logic                  pslverrReg;
    logic                  setupPhase;
    logic                  xferDone;
    logic                  wrMode;
    logic                  wrCmd;
    logic                  rdStatus;
    logic                  rdResult;
    logic                  knownAddr;
    logic                  keyOk;
    logic                  codeOk;
    logic                  accept;
    logic                  badCmd;
    logic [31:0]           modeReg;
    logic                  readyReg;
    logic                  cmdErrReg;
    logic                  lockErrReg;
    logic                  verifyErrReg;
    logic                  opStartReg;
    flc_pkg::flc_op_t      opCmdReg;
    flc_pkg::flc_cmd_word_t cmdWord;
    logic [31:0]           resMem [RES_DEPTH];
    logic [PW-1:0]         wrPtrReg;
    logic [PW:0]           resCountReg;
    logic [PW-1:0]         rdPtrReg;
    logic [31:0]           statusWord;
    logic [31:0]           resultWord;
    logic [31:0]           readMux;
    logic [flc_pkg::EVT_W-1:0] evtSet;
    logic [flc_pkg::EVT_W-1:0] evtStat;
    logic [flc_pkg::EVT_W-1:0] evtMask;
    logic                  readyRise;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // side effects happen only on the completing edge
    assign setupPhase = psel && !penable;
    assign xferDone   = psel && penable && preadyReg;
    assign wrMode     = xferDone && pwrite && (paddr == flc_pkg::ADDR_MODE);
    assign wrCmd      = xferDone && pwrite && (paddr == flc_pkg::ADDR_CMD);
    assign rdStatus   = xferDone && !pwrite && (paddr == flc_pkg::ADDR_STATUS);
    assign rdResult   = xferDone && !pwrite && (paddr == flc_pkg::ADDR_RESULT);
    assign knownAddr  = (paddr == flc_pkg::ADDR_MODE) || (paddr == flc_pkg::ADDR_CMD)
                     || (paddr == flc_pkg::ADDR_STATUS) || (paddr == flc_pkg::ADDR_RESULT)
                     || (paddr == flc_pkg::ADDR_EVT_STAT) || (paddr == flc_pkg::ADDR_EVT_MASK);
    assign cmdWord    = flc_pkg::flc_cmd_word_t'(pwdata);

    flc_cmd_check u_check (
        .cmdWord (cmdWord),
        .keyOk   (keyOk),
        .codeOk  (codeOk)
    );

    assign accept = wrCmd && keyOk && codeOk && readyReg;
    // a write while busy is refused and reported too
    assign badCmd = wrCmd && !(keyOk && codeOk && readyReg);

    // ------------------------------------------------------------
    // apb answer, no wait state
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            preadyReg  <= 1'b0;
            pslverrReg <= 1'b0;
            prdataReg  <= 32'h0000_0000;
        end else begin
            preadyReg  <= setupPhase;
            pslverrReg <= setupPhase && !knownAddr;
            prdataReg  <= (setupPhase && !pwrite) ? readMux : 32'h0000_0000;
        end
    end

    // read data is sampled at setup, so clears use that snapshot
    // ready is bit 0
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[flc_pkg::STS_READY]      = readyReg;
        statusWord[flc_pkg::STS_CMD_ERR]    = cmdErrReg;
        statusWord[flc_pkg::STS_LOCK_ERR]   = lockErrReg;
        statusWord[flc_pkg::STS_VERIFY_ERR] = verifyErrReg;
        // words past the count read zero; with all RES_DEPTH words held the pointer wraps back to word 0
        resultWord = ({1'b0, rdPtrReg} < resCountReg) ? resMem[rdPtrReg] : 32'h0000_0000;
        unique case (paddr)
            flc_pkg::ADDR_MODE:     readMux = modeReg;
            flc_pkg::ADDR_STATUS:   readMux = statusWord;
            flc_pkg::ADDR_RESULT:   readMux = resultWord;
            flc_pkg::ADDR_EVT_STAT: readMux = {28'h000_0000, evtStat};
            flc_pkg::ADDR_EVT_MASK: readMux = {28'h000_0000, evtMask};
            default:                readMux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // mode register
    // ------------------------------------------------------------
    // bit 0 is the ready interrupt enable
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            modeReg <= flc_pkg::MODE_RESET;
        end else if (wrMode) begin
            modeReg <= pwdata & flc_pkg::MODE_WMASK;
        end
    end

    // ------------------------------------------------------------
    // ready flag and command launch
    // ------------------------------------------------------------
    // ready drops as the command is taken
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            readyReg <= 1'b1;
        end else if (accept) begin
            readyReg <= 1'b0;
        end else if (opEnd.done) begin
            readyReg <= 1'b1;
        end
    end

    // launch pulse with code and argument
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            opStartReg <= 1'b0;
            opCmdReg   <= '0;
        end else begin
            opStartReg <= accept;
            if (accept) begin
                opCmdReg <= '{arg: cmdWord.arg, code: cmdWord.code};
            end
        end
    end

    // ------------------------------------------------------------
    // error flags
    // ------------------------------------------------------------
    // set beats the clear of the same write
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdErrReg <= 1'b0;
        end else if (badCmd) begin
            cmdErrReg <= 1'b1;
        end else if (wrCmd || (rdStatus && prdataReg[flc_pkg::STS_CMD_ERR])) begin
            // cleared by command write or status read
            cmdErrReg <= 1'b0;
        end
    end

    // locked region hit, set wins over clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lockErrReg <= 1'b0;
        end else if (opEnd.lockHit) begin
            lockErrReg <= 1'b1;
        end else if (wrCmd || (rdStatus && prdataReg[flc_pkg::STS_LOCK_ERR])) begin
            lockErrReg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            verifyErrReg <= 1'b0;
        end else if (opEnd.done) begin
            verifyErrReg <= opEnd.verifyFail;
        end else if (accept) begin
            verifyErrReg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // result buffer
    // ------------------------------------------------------------
    // words arrive in order from the back end
    always_ff @(posedge core_clk) begin
        if (resValid) begin
            resMem[wrPtrReg] <= resData;
        end
    end

    // count stops at the depth; extra words still write at the wrapped pointer, over word 0
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtrReg    <= PW'(0);
            resCountReg <= (PW+1)'(0);
        end else if (accept) begin
            wrPtrReg    <= PW'(0);
            resCountReg <= (PW+1)'(0);
        end else if (resValid && (resCountReg < (PW+1)'(RES_DEPTH))) begin
            wrPtrReg    <= PW'(wrPtrReg + 1'b1);
            resCountReg <= (PW+1)'(resCountReg + 1'b1);
        end
    end

    // each read steps to the next word
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdPtrReg <= PW'(0);
        end else if (accept) begin
            rdPtrReg <= PW'(0);
        end else if (rdResult) begin
            rdPtrReg <= PW'(rdPtrReg + 1'b1);
        end
    end

    // ------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------
    assign readyRise = opEnd.done && !readyReg;
    always_comb begin
        evtSet = '0;
        evtSet[flc_pkg::STS_READY]      = readyRise;
        evtSet[flc_pkg::STS_CMD_ERR]    = badCmd;
        evtSet[flc_pkg::STS_LOCK_ERR]   = opEnd.lockHit;
        evtSet[flc_pkg::STS_VERIFY_ERR] = opEnd.done && opEnd.verifyFail;
    end

    flc_irq #(
        .W (flc_pkg::EVT_W)
    ) u_irq (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .evtSet      (evtSet),
        .clrWr       (xferDone && pwrite && (paddr == flc_pkg::ADDR_EVT_STAT)),
        .clrData     (pwdata[flc_pkg::EVT_W-1:0]),
        .maskWr      (xferDone && pwrite && (paddr == flc_pkg::ADDR_EVT_MASK)),
        .maskData    (pwdata[flc_pkg::EVT_W-1:0]),
        .levelReq    (readyReg && modeReg[flc_pkg::MODE_RDY_IE]),
        .evtStat_reg (evtStat),
        .evtMask_reg (evtMask),
        .irq_reg     (irq)
    );

    assign prdata  = prdataReg;
    assign pready  = preadyReg;
    assign pslverr = pslverrReg;
    assign opStart = opStartReg;
    assign opCmd   = opCmdReg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_key_gate;
        opStart |-> $past(wrCmd && keyOk && codeOk && readyReg);
    endproperty
    a_key_gate: assert property (p_key_gate) else $error("launch without good key");

    property p_bad_key_drop;
        wrCmd && !keyOk |=> !opStart && (opCmd == $past(opCmd));
    endproperty
    a_bad_key_drop: assert property (p_bad_key_drop) else $error("bad key launched");

    property p_ready_busy;
        (opStart || !readyReg) && !opEnd.done |=> !statusWord[flc_pkg::STS_READY];
    endproperty
    a_ready_busy: assert property (p_ready_busy) else $error("ready while busy");

    property p_ready_irq;
        readyReg && modeReg[flc_pkg::MODE_RDY_IE] |=> irq;
    endproperty
    a_ready_irq: assert property (p_ready_irq) else $error("ready irq missing");

    property p_ready_clear;
        accept |=> !readyReg && $rose(opStart);
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

    property p_cmd_err;
        badCmd |=> cmdErrReg && statusWord[flc_pkg::STS_CMD_ERR];
    endproperty
    a_cmd_err: assert property (p_cmd_err) else $error("command error not set");

    property p_err_clear;
        wrCmd && !badCmd && !opEnd.lockHit |=> !cmdErrReg && !lockErrReg;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("errors not cleared");

    property p_lock_err;
        opEnd.lockHit |=> lockErrReg;
    endproperty
    a_lock_err: assert property (p_lock_err) else $error("lock error not set");

    property p_verify;
        opEnd.done |=> verifyErrReg == $past(opEnd.verifyFail);
    endproperty
    a_verify: assert property (p_verify) else $error("verify flag wrong");

    property p_result_step;
        rdResult && !accept |=> rdPtrReg == PW'($past(rdPtrReg) + 1'b1);
    endproperty
    a_result_step: assert property (p_result_step) else $error("result pointer stuck");

    property p_result_restart;
        accept |=> rdPtrReg == PW'(0) && resCountReg == (PW+1)'(0);
    endproperty
    a_result_restart: assert property (p_result_restart) else $error("pointer not reset");

    c_accept:   cover property (accept ##[1:200] opEnd.done);
    c_bad_key:  cover property (wrCmd && !keyOk);
    c_two_word: cover property (rdResult ##[1:20] rdResult);
    c_irq:      cover property ($rose(irq));
endmodule

/* File: design/flc_irq.sv */
`timescale 1ns/1ns
// sticky event bits, mask and one level interrupt
module flc_irq #(
    parameter int W = 4
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] evtSet,
    input  wire logic         clrWr,
    input  wire logic [W-1:0] clrData,
    input  wire logic         maskWr,
    input  wire logic [W-1:0] maskData,
    input  wire logic         levelReq,
    output logic      [W-1:0] evtStat_reg,
    output logic      [W-1:0] evtMask_reg,
    output logic              irq_reg
);
    // ------------------------------------------------------------
    // sticky status, write one to clear
    // ------------------------------------------------------------
    // set wins so an event in the clearing cycle is kept
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            evtStat_reg <= W'(0);
        end else begin
            evtStat_reg <= (evtStat_reg & ~(clrWr ? clrData : W'(0))) | evtSet;
        end
    end

    // mask register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            evtMask_reg <= W'(0);
        end else if (maskWr) begin
            evtMask_reg <= maskData;
        end
    end

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    // ready level or any unmasked event
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= levelReq || (|(evtStat_reg & evtMask_reg));
        end
    end
endmodule

/* File: design/flc_pkg.sv */
package flc_pkg;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_MODE      = 8'h00;
    localparam logic [7:0]  ADDR_CMD       = 8'h04;
    localparam logic [7:0]  ADDR_STATUS    = 8'h08;
    localparam logic [7:0]  ADDR_RESULT    = 8'h0C;
    localparam logic [7:0]  ADDR_EVT_STAT  = 8'h14;
    localparam logic [7:0]  ADDR_EVT_MASK  = 8'h18;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [31:0] MODE_RESET     = 32'h0400_0000;
    localparam logic [31:0] MODE_WMASK     = 32'h0501_0F01; // writable mode bits
    localparam int          MODE_RDY_IE    = 0;
    localparam int          STS_READY      = 0;
    localparam int          STS_CMD_ERR    = 1;
    localparam int          STS_LOCK_ERR   = 2;
    localparam int          STS_VERIFY_ERR = 3;
    localparam int          EVT_W          = 4;              // same layout as status
    localparam logic [3:0]  EVT_RESET      = 4'h0;
    localparam logic [7:0]  KEY_PASS_VALUE = 8'h5A;
    localparam logic [7:0]  CMD_HOLE       = 8'h06;          // unassigned code
    localparam logic [7:0]  CMD_LAST       = 8'h15;          // highest legal code
    localparam int          RES_DEPTH      = 4;              // result words kept

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  protectKeyField;
        logic [15:0] arg;
        logic [7:0]  code;
    } flc_cmd_word_t;

    typedef struct packed {
        logic [15:0] arg;
        logic [7:0]  code;
    } flc_op_t;

    typedef struct packed {
        logic done;
        logic lockHit;
        logic verifyFail;
    } flc_op_end_t;

endpackage
